//--- design/psl_pkg.sv
// Package holding the register map, setting indices, field positions and timing constants.
`default_nettype none
package psl_pkg;
  // Clock rate and derived tick constants.
  localparam int CLOCK_HZ = 20000000;
  localparam int MS_PER_SEC = 1000;
  localparam int SEC_PER_MIN = 60;
  localparam int MS_PER_MIN = MS_PER_SEC * SEC_PER_MIN;
  localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
  // Register byte offsets on the plain register port.
  localparam logic [8:0] ADDR_CTRL = 9'h000;
  localparam logic [8:0] ADDR_ARC = 9'h004;
  localparam logic [8:0] ADDR_STATUS = 9'h008;
  localparam logic [8:0] ADDR_I2T_A = 9'h00c;
  localparam logic [8:0] ADDR_I2T_B = 9'h010;
  localparam logic [8:0] ADDR_I2T_C = 9'h014;
  localparam logic [1:0] BANK_FIRST = 2'h2;
  localparam logic [1:0] BANK_SECOND = 2'h3;
  // Function bit positions, shared by enables, torque mask and in-service outputs.
  localparam int FN_GROUND_TIME = 0;
  localparam int FN_GROUND_LOW = 1;
  localparam int FN_GROUND_HIGH = 2;
  localparam int FN_PHASE_TIME = 3;
  localparam int FN_PHASE_LOW = 4;
  localparam int FN_PHASE_HIGH = 5;
  // Control register field positions.
  localparam int CTRL_GROUP_SWITCH_ENABLE = 8;
  localparam int CTRL_RECLOSE_ON_AUX = 9;
  localparam int CTRL_TRIP_MONITOR_ENABLE = 10;
  localparam int CTRL_INST_BLOCK_AFTER_RECLOSE = 11;
  localparam int CTRL_RECLOSE_BLOCK_ON_HIGH = 12;
  localparam int CTRL_INST_BLOCK_IN_LOCKOUT = 13;
  localparam int CTRL_SEQ_COORD_ENABLE = 14;
  localparam int CTRL_HIGH_INHIBIT_BY_COORD = 15;
  localparam int CTRL_SERIAL_SECOND_GROUP = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Breaker arc time setting limits and reset value, in milliseconds.
  localparam logic [7:0] ARC_MIN_MS = 8'h14;
  localparam logic [7:0] ARC_MAX_MS = 8'hc8;
  localparam logic [7:0] ARC_RESET = 8'h32;
  // Group-dependent setting table.
  localparam int NUM_GROUP_SETTINGS = 20;
  localparam int SET_W = 16;
  localparam int SET_T_PHASE_LOW = 11;
  localparam int SET_SEQ_DELAY = 16;
  localparam int SET_SEQ_RESTORE = 17;
  localparam int SET_TORQUE = 18;
  localparam int SET_RETURN_DELAY = 19;
  localparam logic [15:0] SET_RESET = 16'h0000;
  localparam logic [5:0] RETURN_MAX_MIN = 6'h3c;
  localparam logic [9:0] RESTORE_MIN_S = 10'h005;
  localparam logic [9:0] RESTORE_MAX_S = 10'h258;
  // Group selection states.
  typedef enum logic [2:0] {
    PSL_GRP_FIRST = 3'b001,
    PSL_GRP_SECOND = 3'b010,
    PSL_GRP_RETURN = 3'b100
  } psl_grp_t;
endpackage : psl_pkg
`default_nettype wire

//--- design/psl_supervision.sv
// Supervisory logic of a feeder relay: function gating, setting groups, reclose interplay and I2T.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`default_nettype none
module psl_supervision
  import psl_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic torque_contact_closed,
  input wire logic group_contact_closed,
  input wire logic breaker_aux_52b,
  input wire logic downstream_recloser_operated,
  input wire logic trip_voltage_present,
  input wire logic trip_issued,
  input wire logic inst_pickup,
  input wire logic high_set_operated,
  input wire logic current_above_toc_pickup,
  input wire logic recloser_after_first_close,
  input wire logic recloser_lockout,
  input wire logic [15:0] pole_a_current_sq,
  input wire logic [15:0] pole_b_current_sq,
  input wire logic [15:0] pole_c_current_sq,
  output logic [5:0] function_in_service,
  output logic second_group_active,
  output logic reclose_pause,
  output logic reclose_inhibit,
  output logic recloser_start,
  output logic trip_monitor_active,
  output logic trip_monitor_alarm,
  output logic coord_active
);

  // Software-visible control and arc time settings.
  logic [31:0] ctrl;
  logic [7:0] arc_time;
  // Two copies of the group-dependent settings.
  logic [SET_W-1:0] first_set [NUM_GROUP_SETTINGS];
  logic [SET_W-1:0] second_set [NUM_GROUP_SETTINGS];
  // Per-pole cumulative I2T totals in amp-squared milliseconds.
  logic [31:0] i2t_total [3];
  // Contact synchroniser stages and the previous synchronised value for edges.
  logic [4:0] sync_first, sync_second, sync_prev;
  // Millisecond tick generator.
  logic [31:0] ms_count;
  logic ms_tick;
  // Group selection state and timing.
  psl_grp_t grp_state, next_grp_state;
  logic by_serial;
  logic [21:0] ret_ms;
  // Sequence coordination state.
  logic [16:0] coord_ms;
  logic coord_timing;
  logic [19:0] restore_ms;
  // Arc interval counter for the I2T window.
  logic [7:0] arc_ms;
  logic arc_open;
  // Latched high-set operation used by the reclose inhibit.
  logic high_set_seen;
  // Synchronised contact names.
  wire torque_closed = sync_second[0];
  wire group_closed = sync_second[1];
  wire aux_52b = sync_second[2];
  wire downstream_op = sync_second[3];
  wire tv_present = sync_second[4];
  wire aux_rise = sync_second[2] & ~sync_prev[2];
  wire downstream_rise = sync_second[3] & ~sync_prev[3];
  // Register decode.
  wire [1:0] bank = reg_addr[8:7];
  wire [4:0] set_idx = reg_addr[6:2];
  wire idx_ok = (set_idx < 5'(NUM_GROUP_SETTINGS)) && (reg_addr[1:0] == 2'h0);
  wire wr_ctrl = reg_write && (reg_addr == ADDR_CTRL);
  wire wr_arc = reg_write && (reg_addr == ADDR_ARC);
  wire wr_first = reg_write && (bank == BANK_FIRST) && idx_ok;
  wire wr_second = reg_write && (bank == BANK_SECOND) && idx_ok;
  wire [2:0] wr_i2t = {reg_write && (reg_addr == ADDR_I2T_C),
                       reg_write && (reg_addr == ADDR_I2T_B),
                       reg_write && (reg_addr == ADDR_I2T_A)};
  // Active group selection of each setting.
  wire use_second = (grp_state != PSL_GRP_FIRST);
  wire [SET_W-1:0] act_torque = use_second ? second_set[SET_TORQUE] : first_set[SET_TORQUE];
  wire [SET_W-1:0] act_return = use_second ? second_set[SET_RETURN_DELAY] : first_set[SET_RETURN_DELAY];
  wire [SET_W-1:0] act_seq_dly = use_second ? second_set[SET_SEQ_DELAY] : first_set[SET_SEQ_DELAY];
  wire [SET_W-1:0] act_seq_res = use_second ? second_set[SET_SEQ_RESTORE] : first_set[SET_SEQ_RESTORE];
  wire [SET_W-1:0] act_t_low = use_second ? second_set[SET_T_PHASE_LOW] : first_set[SET_T_PHASE_LOW];
  // Torque mask: an open contact disables every marked function; zero marks none.
  wire [5:0] torque_mask = act_torque[5:0];
  wire [5:0] torque_drop = torque_closed ? 6'h00 : torque_mask;
  // Enables with the high-set dependency on the matching low-set.
  wire [5:0] en = ctrl[5:0];
  wire [5:0] en_eff = {en[FN_PHASE_HIGH] & en[FN_PHASE_LOW],
                       en[FN_PHASE_LOW], en[FN_PHASE_TIME],
                       en[FN_GROUND_HIGH] & en[FN_GROUND_LOW],
                       en[FN_GROUND_LOW], en[FN_GROUND_TIME]};
  // Instantaneous blocking from the recloser state.
  wire blk_after = ctrl[CTRL_INST_BLOCK_AFTER_RECLOSE] & (recloser_after_first_close | recloser_lockout);
  wire blk_lockout = ctrl[CTRL_INST_BLOCK_IN_LOCKOUT] & recloser_lockout;
  wire inst_block = blk_after | blk_lockout;
  wire low_coord_drop = coord_active;
  wire high_coord_drop = coord_active & ctrl[CTRL_HIGH_INHIBIT_BY_COORD];
  wire [5:0] inst_drop = {inst_block | high_coord_drop, inst_block | low_coord_drop, 1'b0,
                          inst_block | high_coord_drop, inst_block | low_coord_drop, 1'b0};
  wire [5:0] next_in_service = en_eff & ~torque_drop & ~inst_drop;
  // Group requests from the contact and the serial command.
  wire grp_enable = ctrl[CTRL_GROUP_SWITCH_ENABLE];
  wire serial_req = ctrl[CTRL_SERIAL_SECOND_GROUP];
  wire grp_req = by_serial ? serial_req : group_closed;
  wire [5:0] ret_min = (act_return[5:0] > RETURN_MAX_MIN) ? RETURN_MAX_MIN : act_return[5:0];
  wire [21:0] ret_target = 22'(ret_min) * 22'(MS_PER_MIN);
  // Coordination window and restore length in milliseconds.
  wire [16:0] coord_window = 17'(act_t_low) + 17'(act_seq_dly);
  wire [9:0] res_raw = act_seq_res[9:0];
  wire [9:0] res_sec = (res_raw < RESTORE_MIN_S) ? RESTORE_MIN_S :
                       (res_raw > RESTORE_MAX_S) ? RESTORE_MAX_S : res_raw;
  wire [19:0] res_target = 20'(res_sec) * 20'(MS_PER_SEC);
  // Arc time kept inside its range.
  wire [7:0] arc_eff = (arc_time < ARC_MIN_MS) ? ARC_MIN_MS :
                       (arc_time > ARC_MAX_MS) ? ARC_MAX_MS : arc_time;
  wire [15:0] pole_sq [3];
  assign pole_sq[0] = pole_a_current_sq;
  assign pole_sq[1] = pole_b_current_sq;
  assign pole_sq[2] = pole_c_current_sq;
  // Read multiplexer; unmapped addresses read zero.
  wire [31:0] status_word = {19'h0, coord_active, trip_monitor_alarm, reclose_inhibit, reclose_pause,
                             second_group_active, 2'h0, function_in_service};
  wire [31:0] next_rdata = (reg_addr == ADDR_CTRL) ? ctrl :
                           (reg_addr == ADDR_ARC) ? {24'h0, arc_time} :
                           (reg_addr == ADDR_STATUS) ? status_word :
                           (reg_addr == ADDR_I2T_A) ? i2t_total[0] :
                           (reg_addr == ADDR_I2T_B) ? i2t_total[1] :
                           (reg_addr == ADDR_I2T_C) ? i2t_total[2] :
                           (bank == BANK_FIRST && idx_ok) ? {16'h0, first_set[set_idx]} :
                           (bank == BANK_SECOND && idx_ok) ? {16'h0, second_set[set_idx]} : 32'h0;
  // Two flip-flops on every contact before any logic looks at it.
  always_ff @(posedge clock) begin
    if (reset) begin
      sync_first <= 5'h00;
      sync_second <= 5'h00;
      sync_prev <= 5'h00;
    end else begin
      sync_first <= {trip_voltage_present, downstream_recloser_operated, breaker_aux_52b,
                     group_contact_closed, torque_contact_closed};
      sync_second <= sync_first;
      sync_prev <= sync_second;
    end
  end
  // Free-running millisecond tick; all long timers count these ticks.
  always_ff @(posedge clock) begin
    if (reset) begin
      ms_count <= 32'h0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_count == 32'(MS_CYCLES - 1));
      ms_count <= (ms_count == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_count + 32'h1;
    end
  end
  // Control and arc time registers.
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      arc_time <= ARC_RESET;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata;
      if (wr_arc) arc_time <= reg_wdata[7:0];
    end
  end
  // Setting tables; each copy is written only through its own bank.
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < NUM_GROUP_SETTINGS; i++) begin
        first_set[i] <= SET_RESET;
        second_set[i] <= SET_RESET;
      end
    end else begin
      if (wr_first) first_set[set_idx] <= reg_wdata[SET_W-1:0];
      if (wr_second) second_set[set_idx] <= reg_wdata[SET_W-1:0];
    end
  end
  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 32'h0;
    end
  end
  // Next group state. Disabling the switch forces the first group at once.
  always_comb begin
    next_grp_state = grp_state;
    case (grp_state)
      PSL_GRP_FIRST: begin
        if (grp_enable && (group_closed || serial_req)) begin
          next_grp_state = PSL_GRP_SECOND;
        end
      end
      PSL_GRP_SECOND: begin
        if (!grp_req) begin
          next_grp_state = PSL_GRP_RETURN;
        end
      end
      PSL_GRP_RETURN: begin
        if (grp_req) begin
          next_grp_state = PSL_GRP_SECOND;
        end else if (ret_ms >= ret_target) begin
          next_grp_state = PSL_GRP_FIRST;
        end
      end
      default: begin
        next_grp_state = PSL_GRP_FIRST;
      end
    endcase
    if (!grp_enable) begin
      next_grp_state = PSL_GRP_FIRST;
    end
  end
  // Group state, its source, and the return timer which restarts on each entry to return.
  always_ff @(posedge clock) begin
    if (reset) begin
      grp_state <= PSL_GRP_FIRST;
      by_serial <= 1'b0;
      ret_ms <= 22'h0;
      second_group_active <= 1'b0;
    end else begin
      grp_state <= next_grp_state;
      second_group_active <= (next_grp_state != PSL_GRP_FIRST);
      if (grp_state == PSL_GRP_FIRST) by_serial <= serial_req; // The serial command wins when both ask together.
      if (grp_state != PSL_GRP_RETURN) begin
        ret_ms <= 22'h0;
      end else if (ms_tick) begin
        ret_ms <= ret_ms + 22'h1;
      end
    end
  end
  // Sequence coordination: the window opens on instantaneous pickup; a downstream operation
  // inside it takes the low-set functions out for the restore time, and the high-sets only with CTRL_HIGH_INHIBIT_BY_COORD.
  always_ff @(posedge clock) begin
    if (reset) begin
      coord_timing <= 1'b0;
      coord_ms <= 17'h0;
      coord_active <= 1'b0;
      restore_ms <= 20'h0;
    end else if (!ctrl[CTRL_SEQ_COORD_ENABLE]) begin
      coord_timing <= 1'b0;
      coord_ms <= 17'h0;
      coord_active <= 1'b0;
      restore_ms <= 20'h0;
    end else if (coord_active) begin
      // Restore runs on its own; a new operation does not extend it.
      if (restore_ms >= res_target) begin
        coord_active <= 1'b0;
      end else if (ms_tick) begin
        restore_ms <= restore_ms + 20'h1;
      end
    end else if (coord_timing) begin
      if (downstream_rise || downstream_op) begin
        coord_active <= 1'b1;
        coord_timing <= 1'b0;
        restore_ms <= 20'h0;
      end else if (coord_ms >= coord_window || !inst_pickup) begin
        coord_timing <= 1'b0;
      end else if (ms_tick) begin
        coord_ms <= coord_ms + 17'h1;
      end
    end else if (inst_pickup) begin
      coord_timing <= 1'b1;
      coord_ms <= 17'h0;
    end
  end
  // Function gating and recloser-facing outputs.
  always_ff @(posedge clock) begin
    if (reset) begin
      function_in_service <= 6'h00;
      reclose_pause <= 1'b0;
      high_set_seen <= 1'b0;
      reclose_inhibit <= 1'b0;
      recloser_start <= 1'b0;
    end else begin
      function_in_service <= next_in_service;
      // Pause tracks current while blk_after blocks (not under blk_lockout alone), even with time overcurrent out of service,
      // so the recloser stays in its paused reset delay until current falls.
      reclose_pause <= blk_after & current_above_toc_pickup;
      // A high-set operation is held until the recloser leaves its sequence and lockout;
      // a new operation in the clearing cycle is kept.
      if (high_set_operated) begin
        high_set_seen <= 1'b1;
      end else if (!recloser_after_first_close && !recloser_lockout) begin
        high_set_seen <= 1'b0;
      end
      reclose_inhibit <= ctrl[CTRL_RECLOSE_BLOCK_ON_HIGH] & (high_set_operated | high_set_seen);
      recloser_start <= trip_issued | (ctrl[CTRL_RECLOSE_ON_AUX] & aux_rise);
    end
  end
  // Trip voltage monitor only supervises when enabled.
  always_ff @(posedge clock) begin
    if (reset) begin
      trip_monitor_active <= 1'b0;
      trip_monitor_alarm <= 1'b0;
    end else begin
      trip_monitor_active <= ctrl[CTRL_TRIP_MONITOR_ENABLE];
      trip_monitor_alarm <= ctrl[CTRL_TRIP_MONITOR_ENABLE] & ~tv_present;
    end
  end
  // I2T window: each trip opens an arc-time interval during which I squared is summed per ms.
  // A trip while the window is open restarts it rather than being lost.
  always_ff @(posedge clock) begin
    if (reset) begin
      arc_open <= 1'b0;
      arc_ms <= 8'h00;
    end else if (trip_issued) begin
      arc_open <= 1'b1;
      arc_ms <= 8'h00;
    end else if (arc_open && ms_tick) begin
      arc_ms <= arc_ms + 8'h01;
      if (arc_ms + 8'h01 >= arc_eff) begin
        arc_open <= 1'b0;
      end
    end
  end
  // Per-pole totals; a software clear in the same cycle as an accumulation restarts the total from that sample.
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int p = 0; p < 3; p++) begin
        i2t_total[p] <= 32'h0;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (arc_open && ms_tick) begin
          i2t_total[p] <= (wr_i2t[p] ? 32'h0 : i2t_total[p]) + 32'(pole_sq[p]);
        end else if (wr_i2t[p]) begin
          i2t_total[p] <= 32'h0;
        end
      end
    end
  end
endmodule : psl_supervision
`default_nettype wire

//--- sim/psl_monitor.sv
// Port checker for the supervision block, bound to every instance of it.
`default_nettype none
module psl_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic reg_write,
  input wire logic trip_issued,
  input wire logic high_set_operated,
  input wire logic current_above_toc_pickup,
  input wire logic recloser_after_first_close,
  input wire logic recloser_lockout,
  input wire logic [5:0] function_in_service,
  input wire logic second_group_active,
  input wire logic reclose_pause,
  input wire logic reclose_inhibit,
  input wire logic recloser_start,
  input wire logic trip_monitor_active,
  input wire logic trip_monitor_alarm,
  input wire logic coord_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // Every check samples on the system clock; all but chk_reset_quiet rest while reset is held.
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Recloser sits between first reclose and reset, or in lockout.
  wire logic held_state = recloser_after_first_close || recloser_lockout;
  chk_start_on_trip: assert property (trip_issued |=> recloser_start)
    else $error("recloser start missing after own trip");
  chk_pause_cause: assert property (reclose_pause |-> $past(current_above_toc_pickup) && $past(held_state))
    else $error("pause raised without cause");
  chk_pause_drop: assert property (!current_above_toc_pickup |=> !reclose_pause)
    else $error("pause kept below pickup");
  // A write one edge earlier may have changed the blocking setting that the next pause value uses.
  chk_pause_hold: assert property (reclose_pause && current_above_toc_pickup && held_state
    && !$past(reg_write) |=> reclose_pause)
    else $error("pause released above pickup");
  chk_inst_blocked: assert property (reclose_pause |-> (function_in_service & 6'h36) == 6'h00)
    else $error("instantaneous function in service while paused");
  chk_monitor_gate: assert property (trip_monitor_alarm |-> trip_monitor_active)
    else $error("alarm from an inactive monitor");
  chk_reset_quiet: assert property (disable iff (1'b0) reset |=> function_in_service == 6'h00
    && !second_group_active && !coord_active)
    else $error("outputs active after reset");
  chk_coord_drop: assert property (coord_active && $past(coord_active)
    |-> (function_in_service & 6'h12) == 6'h00)
    else $error("low-set in service during coordination");
  chk_inhibit_cause: assert property ($rose(reclose_inhibit)
    |-> $past(high_set_operated) || $past(high_set_operated, 2))
    else $error("inhibit without high-set operation");
endmodule : psl_monitor
bind psl_supervision psl_monitor psl_monitor_i (.*);
`default_nettype wire

//--- sim/psl_field_model.sv
// Breaker and downstream recloser seen from the relay's contact inputs.
`default_nettype none
module psl_field_model #(
  parameter int OPEN_CYCLES = 6,
  parameter int FAST_CYCLES = 2,
  parameter int SLOW_CYCLES = 60
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic trip_issued,
  input wire logic inst_pickup,
  input wire logic ds_fast,
  output logic breaker_aux_52b,
  output logic downstream_recloser_operated
);
  timeunit 1ns;
  timeprecision 1ns;
  int brk_cnt; // Cycles since the trip; zero when no trip is in progress.
  logic pick_prev; // Pickup at the previous edge, so a held pickup starts only one operation.
  int ds_cnt; // Cycles since the fault was seen downstream.
  int ds_wait; // Operating delay of the downstream recloser.
  assign ds_wait = ds_fast ? FAST_CYCLES : SLOW_CYCLES;
  // The breaker opens some cycles after a trip and recloses later, giving one 52b action.
  assign breaker_aux_52b = brk_cnt > OPEN_CYCLES;
  // The downstream recloser operates for eight cycles, fast or slow as the bench asks.
  assign downstream_recloser_operated = ds_cnt > ds_wait && ds_cnt <= ds_wait + 8;
  // Both counters start on their cause and fall back to idle after their span.
  always_ff @(posedge clock) begin
    if (reset) begin
      brk_cnt <= 0;
      ds_cnt <= 0;
      pick_prev <= 1'b0;
    end else begin
      brk_cnt <= trip_issued ? 1 : (brk_cnt != 0 && brk_cnt < OPEN_CYCLES + 40) ? brk_cnt + 1 : 0;
      // The fault is seen downstream when pickup rises; a pickup held high does not restart it.
      pick_prev <= inst_pickup;
      ds_cnt <= (inst_pickup && !pick_prev) ? 1 : (ds_cnt != 0 && ds_cnt < SLOW_CYCLES + 9) ? ds_cnt + 1 : 0;
    end
  end
endmodule : psl_field_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the supervision block and its field model.
`default_nettype none
module testbench
  import psl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset, reg_write, reg_read, torque_contact_closed, group_contact_closed, breaker_aux_52b;
  logic downstream_recloser_operated, trip_voltage_present, trip_issued, inst_pickup, high_set_operated;
  logic current_above_toc_pickup, recloser_after_first_close, recloser_lockout, ds_fast;
  logic [8:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] pole_a_current_sq, pole_b_current_sq, pole_c_current_sq;
  logic [5:0] function_in_service;
  logic second_group_active, reclose_pause, reclose_inhibit, recloser_start;
  logic trip_monitor_active, trip_monitor_alarm, coord_active;
  int n_fail, n_compared, n_starts, cycles, s0;
  // A millisecond is four cycles here so that the restore time fits the run.
  psl_supervision #(.MS_CYCLES(4)) psl_supervision_i (.*);
  psl_field_model psl_field_model_i (.*);
  always #25 clock = ~clock;
  // Counts recloser start pulses and cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (recloser_start === 1'b1) n_starts++;
    if (cycles == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  // The read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask : rd
  // Lets the synchronisers and gating settle, then reads the status word.
  task automatic st(input logic [31:0] exp);
    tick(12);
    rd(ADDR_STATUS, exp);
  endtask : st
  task automatic set(input int i, input int g, input logic [15:0] v);
    wr(9'(256 + g * 128 + i * 4), {16'h0000, v});
  endtask : set
  task automatic trip();
    trip_issued <= 1'b1;
    tick(1);
    trip_issued <= 1'b0;
    tick(120);
  endtask : trip
  // The window closes when pickup drops, so pickup is held six cycles: long enough for a fast
  // downstream operation to pass the synchroniser, short enough not to reopen the window.
  task automatic pickup();
    inst_pickup <= 1'b1;
    tick(6);
    inst_pickup <= 1'b0;
  endtask : pickup
  initial begin
    {clock, reg_write, reg_read, trip_issued, inst_pickup, high_set_operated, group_contact_closed} = '0;
    {current_above_toc_pickup, recloser_after_first_close, recloser_lockout, reg_addr, reg_wdata} = '0;
    {reset, torque_contact_closed, trip_voltage_present, ds_fast} = 4'hf;
    {pole_a_current_sq, pole_b_current_sq, pole_c_current_sq} = {16'h0003, 16'h0005, 16'h0007};
    tick(3);
    reset <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_ARC, 32'h32);
    wr(ADDR_STATUS, 32'hffff_ffff);
    st(32'h0);
    rd(9'h020, 32'h0);
    $display("Test registers finished");
    wr(ADDR_CTRL, 32'h24);
    st(32'h0);
    wr(ADDR_CTRL, 32'h3f);
    torque_contact_closed <= 1'b0;
    st(32'h3f);
    for (int k = 0; k < 6; k++) begin
      set(SET_TORQUE, 0, 16'(1 << k));
      st(32'h3f & ~(32'h1 << k));
    end
    set(SET_TORQUE, 0, 16'h3);
    st(32'h3c);
    torque_contact_closed <= 1'b1;
    st(32'h3f);
    $display("Test gating finished");
    torque_contact_closed <= 1'b0;
    set(SET_TORQUE, 0, 16'h0);
    set(SET_TORQUE, 1, 16'h3);
    set(SET_RETURN_DELAY, 1, 16'h0);
    group_contact_closed <= 1'b1;
    st(32'h3f);
    wr(ADDR_CTRL, 32'h13f);
    st(32'h13c);
    group_contact_closed <= 1'b0;
    st(32'h3f);
    wr(ADDR_CTRL, 32'h1013f);
    st(32'h13c);
    wr(ADDR_CTRL, 32'h13f);
    st(32'h3f);
    torque_contact_closed <= 1'b1;
    $display("Test groups finished");
    wr(ADDR_ARC, 32'h5);
    wr(ADDR_CTRL, 32'h3f);
    s0 = n_starts;
    trip();
    cmp(32'(n_starts - s0), 32'h1);
    rd(ADDR_I2T_A, 32'h3c);
    rd(ADDR_I2T_B, 32'h64);
    rd(ADDR_I2T_C, 32'h8c);
    wr(ADDR_I2T_A, 32'h0);
    wr(ADDR_CTRL, 32'h23f);
    trip();
    cmp(32'(n_starts - s0), 32'h3);
    rd(ADDR_I2T_A, 32'h3c);
    rd(ADDR_I2T_B, 32'hc8);
    $display("Test recloser start and I2T finished");
    wr(ADDR_CTRL, 32'h83f);
    recloser_after_first_close <= 1'b1;
    current_above_toc_pickup <= 1'b1;
    st(32'h209);
    current_above_toc_pickup <= 1'b0;
    st(32'h09);
    recloser_after_first_close <= 1'b0;
    recloser_lockout <= 1'b1;
    st(32'h09);
    wr(ADDR_CTRL, 32'h203f);
    st(32'h09);
    recloser_lockout <= 1'b0;
    st(32'h3f);
    recloser_after_first_close <= 1'b1;
    current_above_toc_pickup <= 1'b1;
    st(32'h3f);
    high_set_operated <= 1'b1;
    tick(1);
    high_set_operated <= 1'b0;
    st(32'h3f);
    wr(ADDR_CTRL, 32'h103f);
    high_set_operated <= 1'b1;
    tick(1);
    high_set_operated <= 1'b0;
    st(32'h43f);
    recloser_after_first_close <= 1'b0;
    current_above_toc_pickup <= 1'b0;
    st(32'h3f);
    $display("Test blocking finished");
    wr(ADDR_CTRL, 32'h43f);
    st(32'h3f);
    cmp({31'h0, trip_monitor_active}, 32'h1);
    trip_voltage_present <= 1'b0;
    st(32'h83f);
    wr(ADDR_CTRL, 32'h3f);
    st(32'h3f);
    cmp({31'h0, trip_monitor_active}, 32'h0);
    trip_voltage_present <= 1'b1;
    $display("Test monitor finished");
    set(SET_T_PHASE_LOW, 0, 16'h0);
    set(SET_SEQ_DELAY, 0, 16'h2);
    set(SET_SEQ_RESTORE, 0, 16'h5);
    pickup();
    st(32'h3f);
    wr(ADDR_CTRL, 32'h403f);
    ds_fast <= 1'b0;
    pickup();
    tick(60);
    st(32'h3f);
    ds_fast <= 1'b1;
    pickup();
    st(32'h102d);
    tick(21000);
    st(32'h3f);
    wr(ADDR_CTRL, 32'hc03f);
    pickup();
    st(32'h1009);
    $display("Test coordination finished");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
